/* File: design/i2cmc_top.v */
// Mode and transfer clock control of the two-wire serial interface.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "i2cmc_regs.vh"
module i2cmc_top (
  // Clock and reset.
  input  wire       clk_in,
  input  wire       reset_in,
  // Register port.
  input  wire [2:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // Events from the transfer engine, same clock.
  input  wire       arb_lost_in,
  input  wire       overrun_in,
  input  wire       tx_bit_in,
  input  wire       tx_drive_in,
  // Serial clock pin.
  input  wire       scl_in,
  output wire       scl_out,
  output wire       scl_oe_out,
  // Serial data pin.
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_out,
  // Pin function and mode status.
  output wire       port_function_out,
  output wire [1:0] mode_out,
  output wire       rx_enabled_out,
  // Interrupt.
  output wire       irq_out
);

  // ************************************************************
  // Declarations
  // ************************************************************
  reg  [7:0] ctrl_r;         // bus_control_one register.
  reg  [7:0] ctrl_nxt;       // Next value with hardware updates.
  reg  [6:0] own_addr_r;     // own_slave_address register.
  reg        sync_format_r;  // High selects the clocked synchronous format.
  reg  [3:0] int_status_r;   // Sticky event bits.
  reg  [3:0] int_enable_r;   // Interrupt enable bits.
  reg  [3:0] int_set;        // Events raised this cycle.
  reg  [7:0] rx_buffer_r;    // received_data_buffer register.
  reg  [7:0] shift_r;        // Receive shift register.
  reg  [3:0] bit_count_r;    // Bits seen in the current frame.
  reg        first_byte_r;   // High until the first frame after a start ends.
  reg        rx_enable_r;    // High while the next reception is allowed.
  reg        scl_prev_r;     // Previous synchronised serial clock.
  reg        sda_prev_r;     // Previous synchronised serial data.
  wire [1:0] pins_sync;      // Synchronised serial clock and data.
  wire       scl_s;          // Synchronised serial clock.
  wire       sda_s;          // Synchronised serial data.
  wire       scl_gen;        // Generated master serial clock.
  wire       enable;         // interface_enable bit.
  wire       master;         // master_select bit.
  wire       transmit;       // transmit_select bit.
  wire       scl_rise;       // Rising edge of the serial clock.
  wire       start_seen;     // Start condition on the bus.
  wire       byte_done;      // Last data bit of a byte shifted in.
  wire       frame_end;      // Last clock of a frame.
  wire [7:0] rx_byte;        // Byte including the bit now sampled.
  wire       addr_match;     // Own address match with read bit.
  wire       wr_ctrl;        // Write to bus_control_one.
  wire       rd_buffer;      // Read of received_data_buffer.

  assign enable   = ctrl_r[`I2CMC_BIT_ENABLE];
  assign master   = ctrl_r[`I2CMC_BIT_MASTER];
  assign transmit = ctrl_r[`I2CMC_BIT_TRANSMIT];
  assign wr_ctrl  = wr_in && (addr_in == `I2CMC_OFS_CTRL_ONE);
  assign rd_buffer = rd_in && (addr_in == `I2CMC_OFS_RX_BUFFER);

  // ************************************************************
  // Pin synchronisers and serial clock generator
  // ************************************************************
  i2cmc_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_sync)
  );
  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // Runs only for an enabled master; a slave ignores the divider code.
  i2cmc_clk_gen u_clk_gen (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .run_in      (enable && master),
    .div_sel_in  (ctrl_r[`I2CMC_DIV_HI:`I2CMC_DIV_LO]),
    .scl_gen_out (scl_gen)
  );

  // ************************************************************
  // Pin control
  // ************************************************************
  // Disabled: pins are released to port use and nothing is driven.
  assign port_function_out = !enable;
  // Synchronous master drives a full clock; I2C master pulls low only.
  assign scl_out    = sync_format_r ? scl_gen : 1'b0;
  assign scl_oe_out = enable && master &&
                      (sync_format_r || !scl_gen);
  // Transmit data goes out while enabled and the engine drives; only the synchronous format also needs transmit mode.
  assign sda_out    = sync_format_r ? tx_bit_in : 1'b0;
  assign sda_oe_out = enable && tx_drive_in && (transmit || !sync_format_r) &&
                      (sync_format_r || !tx_bit_in);
  assign mode_out   = {master, transmit};
  assign rx_enabled_out = rx_enable_r;

  // ************************************************************
  // Receive path
  // ************************************************************
  assign scl_rise   = enable && scl_s && !scl_prev_r;
  assign start_seen = enable && !sync_format_r && scl_s && scl_prev_r &&
                      sda_prev_r && !sda_s;
  assign rx_byte    = {shift_r[6:0], sda_s};
  assign byte_done  = scl_rise && (bit_count_r == `I2CMC_BITS_SYNC - 4'h1);
  assign frame_end  = scl_rise && (bit_count_r == (sync_format_r ?
                      `I2CMC_BITS_SYNC : `I2CMC_BITS_I2C) - 4'h1);
  // Address byte after a start that names this node with the read bit.
  assign addr_match = byte_done && first_byte_r && !sync_format_r &&
                      !master && !transmit &&
                      (rx_byte[7:1] == own_addr_r) && rx_byte[0];

  // Shifts bits in, counts the bits of each frame and tracks the previous pin levels.
  always @(posedge clk_in) begin
    if (reset_in || !enable) begin
      shift_r      <= 8'h00;
      bit_count_r  <= 4'h0;
      first_byte_r <= 1'b0;
      scl_prev_r   <= 1'b1;
      sda_prev_r   <= 1'b1;
    end else begin
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
      if (start_seen) begin
        bit_count_r  <= 4'h0;
        first_byte_r <= 1'b1;
      end else if (frame_end) begin
        bit_count_r  <= 4'h0;
        first_byte_r <= 1'b0;
      end else if (scl_rise) begin
        bit_count_r <= bit_count_r + 4'h1;
        if (bit_count_r < `I2CMC_BITS_SYNC) begin
          shift_r <= rx_byte;
        end
      end
    end
  end

  // Holds the last received byte and the permission for the next one.
  always @(posedge clk_in) begin
    if (reset_in) begin
      rx_buffer_r <= 8'h00;
      rx_enable_r <= 1'b1;
    end else begin
      if (byte_done && !transmit && rx_enable_r) begin
        rx_buffer_r <= rx_byte;
      end
      if (rd_buffer && !transmit) begin
        // Reading rearms reception unless the inhibit bit is set.
        rx_enable_r <= !ctrl_r[`I2CMC_BIT_RX_INHIBIT];
      end else if (byte_done && !transmit && rx_enable_r) begin
        rx_enable_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Control register with hardware mode changes
  // ************************************************************
  // Software write first, then hardware events override it.
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      // Software should only change the transmit bit between frames.
      ctrl_nxt = wdata_in;
    end
    if (arb_lost_in && master && !sync_format_r) begin
      ctrl_nxt[`I2CMC_BIT_MASTER]   = 1'b0;
      ctrl_nxt[`I2CMC_BIT_TRANSMIT] = 1'b0;
    end
    if (overrun_in && master && sync_format_r) begin
      ctrl_nxt[`I2CMC_BIT_MASTER] = 1'b0;
    end
    if (addr_match) begin
      ctrl_nxt[`I2CMC_BIT_TRANSMIT] = 1'b1;
    end
  end

  // Registers written by software.
  always @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_r        <= `I2CMC_RST_CTRL_ONE;
      own_addr_r    <= `I2CMC_RST_OWN_ADDR;
      sync_format_r <= 1'b0;
      int_enable_r  <= `I2CMC_RST_INT_ENABLE;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_in && (addr_in == `I2CMC_OFS_OWN_ADDR)) begin
        own_addr_r <= wdata_in[7:1];
      end
      if (wr_in && (addr_in == `I2CMC_OFS_FORMAT)) begin
        sync_format_r <= wdata_in[0];
      end
      if (wr_in && (addr_in == `I2CMC_OFS_INT_ENABLE)) begin
        int_enable_r <= wdata_in[3:0];
      end
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // Collects this cycle's events into status bit positions.
  always @* begin
    int_set = 4'h0;
    int_set[`I2CMC_INT_ARB_LOST]   = arb_lost_in && master && !sync_format_r;
    int_set[`I2CMC_INT_OVERRUN]    = overrun_in && master && sync_format_r;
    int_set[`I2CMC_INT_ADDR_MATCH] = addr_match;
    int_set[`I2CMC_INT_RX_FULL]    = byte_done && !transmit && rx_enable_r;
  end

  // A clear write removes bits, but an event in the same cycle wins.
  always @(posedge clk_in) begin
    if (reset_in) begin
      int_status_r <= 4'h0;
    end else if (wr_in && (addr_in == `I2CMC_OFS_INT_CLEAR)) begin
      int_status_r <= (int_status_r & ~wdata_in[3:0]) | int_set;
    end else begin
      int_status_r <= int_status_r | int_set;
    end
  end

  assign irq_out = |(int_status_r & int_enable_r);

  // ************************************************************
  // Read data
  // ************************************************************
  // Read data appear in the cycle after the strobe; otherwise zero.
  always @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `I2CMC_OFS_CTRL_ONE:   rdata_out <= ctrl_r;
        `I2CMC_OFS_OWN_ADDR:   rdata_out <= {own_addr_r, 1'b0};
        `I2CMC_OFS_FORMAT:     rdata_out <= {7'h00, sync_format_r};
        `I2CMC_OFS_INT_STATUS: rdata_out <= {4'h0, int_status_r};
        `I2CMC_OFS_INT_ENABLE: rdata_out <= {4'h0, int_enable_r};
        `I2CMC_OFS_RX_BUFFER:  rdata_out <= rx_buffer_r;
        default:               rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule // i2cmc_top

/* File: design/i2cmc_regs.vh */
// Register offsets, field positions, reset values and timing counts for the mode and clock block.
`ifndef I2CMC_REGS_VH
`define I2CMC_REGS_VH

// ************************************************************
// Register offsets on the plain register port
// ************************************************************
`define I2CMC_OFS_CTRL_ONE    3'h0
`define I2CMC_OFS_OWN_ADDR    3'h1
`define I2CMC_OFS_FORMAT      3'h2
`define I2CMC_OFS_INT_STATUS  3'h3
`define I2CMC_OFS_INT_CLEAR   3'h4
`define I2CMC_OFS_INT_ENABLE  3'h5
`define I2CMC_OFS_RX_BUFFER   3'h6

// ************************************************************
// Field positions of bus_control_one
// ************************************************************
`define I2CMC_BIT_ENABLE      7
`define I2CMC_BIT_RX_INHIBIT  6
`define I2CMC_BIT_MASTER      5
`define I2CMC_BIT_TRANSMIT    4
`define I2CMC_DIV_HI          3
`define I2CMC_DIV_LO          0

// ************************************************************
// Interrupt status bit positions
// ************************************************************
`define I2CMC_INT_ARB_LOST    0
`define I2CMC_INT_OVERRUN     1
`define I2CMC_INT_ADDR_MATCH  2
`define I2CMC_INT_RX_FULL     3
`define I2CMC_INT_COUNT       4

// ************************************************************
// Reset values
// ************************************************************
`define I2CMC_RST_CTRL_ONE    8'h00
`define I2CMC_RST_OWN_ADDR    7'h00
`define I2CMC_RST_INT_ENABLE  4'h0

// ************************************************************
// Serial clock periods in system clock cycles, per divider code
// ************************************************************
`define I2CMC_PER_0  9'h01C
`define I2CMC_PER_1  9'h028
`define I2CMC_PER_2  9'h030
`define I2CMC_PER_3  9'h040
`define I2CMC_PER_4  9'h050
`define I2CMC_PER_5  9'h064
`define I2CMC_PER_6  9'h070
`define I2CMC_PER_7  9'h080
`define I2CMC_PER_8  9'h038
`define I2CMC_PER_9  9'h050
`define I2CMC_PER_A  9'h060
`define I2CMC_PER_B  9'h080
`define I2CMC_PER_C  9'h0A0
`define I2CMC_PER_D  9'h0C8
`define I2CMC_PER_E  9'h0E0
`define I2CMC_PER_F  9'h100

// ************************************************************
// Bits per frame on the wire
// ************************************************************
`define I2CMC_BITS_I2C        4'h9
`define I2CMC_BITS_SYNC       4'h8

`endif

/* File: design/i2cmc_sync.v */
// Two flip-flop synchroniser for pin inputs, one stage pair per bit.
`timescale 1ns/1ps
module i2cmc_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset.
  input  wire             clk_in,
  input  wire             reset_in,
  // Asynchronous levels in, synchronised levels out.
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ************************************************************
  // Synchroniser stages
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_r;   // First stage, read only by the second stage.
      reg stable_r; // Second stage, safe for logic.
      // Idle bus lines are high, so both stages reset high.
      always @(posedge clk_in) begin
        if (reset_in) begin
          meta_r   <= 1'b1;
          stable_r <= 1'b1;
        end else begin
          meta_r   <= async_in[g];
          stable_r <= meta_r;
        end
      end
      assign sync_out[g] = stable_r;
    end
  endgenerate

endmodule // i2cmc_sync

/* File: design/i2cmc_clk_gen.v */
// Master serial clock generator driven by the four-bit divider code.
`timescale 1ns/1ps
`include "i2cmc_regs.vh"
module i2cmc_clk_gen (
  // Clock and reset.
  input  wire       clk_in,
  input  wire       reset_in,
  // Control.
  input  wire       run_in,
  input  wire [3:0] div_sel_in,
  // Generated clock.
  output reg        scl_gen_out
);

  reg [8:0] period;    // Selected period in system clocks.
  reg [8:0] count_r;   // Position within the current period.
  reg [8:0] count_nxt; // Next count value.

  // ************************************************************
  // Divider lookup
  // ************************************************************
  // Maps the divider code to a whole serial clock period.
  always @* begin
    case (div_sel_in)
      4'h0:    period = `I2CMC_PER_0;
      4'h1:    period = `I2CMC_PER_1;
      4'h2:    period = `I2CMC_PER_2;
      4'h3:    period = `I2CMC_PER_3;
      4'h4:    period = `I2CMC_PER_4;
      4'h5:    period = `I2CMC_PER_5;
      4'h6:    period = `I2CMC_PER_6;
      4'h7:    period = `I2CMC_PER_7;
      4'h8:    period = `I2CMC_PER_8;
      4'h9:    period = `I2CMC_PER_9;
      4'hA:    period = `I2CMC_PER_A;
      4'hB:    period = `I2CMC_PER_B;
      4'hC:    period = `I2CMC_PER_C;
      4'hD:    period = `I2CMC_PER_D;
      4'hE:    period = `I2CMC_PER_E;
      default: period = `I2CMC_PER_F;
    endcase
  end

  // Wraps at the end of the period; a shrinking code restarts it cleanly.
  always @* begin
    if (count_r >= period - 9'h001) begin
      count_nxt = 9'h000;
    end else begin
      count_nxt = count_r + 9'h001;
    end
  end

  // ************************************************************
  // Phase counter
  // ************************************************************
  // First half of the period is low, second half high; idle high.
  // Idle parks the count at all ones, which always wraps to zero on the first
  // running edge, so the first low phase is as long as every later one.
  always @(posedge clk_in) begin
    if (reset_in) begin
      count_r     <= 9'h1FF;
      scl_gen_out <= 1'b1;
    end else if (!run_in) begin
      count_r     <= 9'h1FF;
      scl_gen_out <= 1'b1;
    end else begin
      count_r     <= count_nxt;
      scl_gen_out <= (count_nxt >= {1'b0, period[8:1]});
    end
  end

endmodule // i2cmc_clk_gen

/* File: tb/i2cmc_checker_assertions.sv */
// Port-level checks of the mode and clock control block.
`timescale 1ns/1ps
module i2cmc_checker (
  // Clock and reset.
  input wire       clk_in,
  input wire       reset_in,
  // Register port.
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  // Engine events.
  input wire       arb_lost_in,
  input wire       overrun_in,
  input wire       tx_bit_in,
  input wire       tx_drive_in,
  // Pins.
  input wire       scl_in,
  input wire       scl_out,
  input wire       scl_oe_out,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe_out,
  // Status.
  input wire       port_function_out,
  input wire [1:0] mode_out,
  input wire       rx_enabled_out,
  input wire       irq_out
);
  reg fmt_r; // Shadow of the format bit, set means clocked synchronous.
  reg inh_r; // Shadow of next_receive_inhibit.
  // ************************************************************
  // Shadow registers follow software writes.
  // ************************************************************
  always @(posedge clk_in) begin
    if (reset_in) begin
      fmt_r <= 1'b0;
      inh_r <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == 3'h2) fmt_r <= wdata_in[0];
      if (addr_in == 3'h0) inh_r <= wdata_in[6];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  property p_halt;
    port_function_out |-> !scl_oe_out && !sda_oe_out;
  endproperty
  a_halt: assert property (p_halt) else $error("pins driven while halted");
  property p_enable;
    wr_in && addr_in == 3'h0 && wdata_in[7] |=> !port_function_out;
  endproperty
  a_enable: assert property (p_enable) else $error("pins not handed to bus");
  property p_mode;
    wr_in && addr_in == 3'h0 && !arb_lost_in && !overrun_in |=>
      mode_out == $past(wdata_in[5:4]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode differs from written bits");
  property p_arb;
    arb_lost_in && mode_out[1] && !fmt_r |=> mode_out == 2'b00;
  endproperty
  a_arb: assert property (p_arb) else $error("no fall back after lost arbitration");
  property p_ovr;
    overrun_in && mode_out[1] && fmt_r |=> !mode_out[1] && mode_out[0] == $past(mode_out[0]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("master kept after overrun");
  property p_sclk;
    fmt_r && mode_out[1] && !port_function_out |-> scl_oe_out;
  endproperty
  a_sclk: assert property (p_sclk) else $error("sync master not driving clock");
  property p_slave;
    !mode_out[1] |-> !scl_oe_out;
  endproperty
  a_slave: assert property (p_slave) else $error("slave drives clock");
  property p_rearm;
    rd_in && addr_in == 3'h6 && !mode_out[0] |=> rx_enabled_out == !inh_r;
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm after buffer read wrong");
  c_arb: cover property (arb_lost_in && mode_out[1] && !fmt_r);
  c_ovr: cover property (overrun_in && mode_out[1] && fmt_r);
  c_rearm: cover property (rd_in && addr_in == 3'h6 && !mode_out[0]);
endmodule // i2cmc_checker
bind i2cmc_top i2cmc_checker i_i2cmc_checker (.clk_in, .reset_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .arb_lost_in, .overrun_in, .tx_bit_in, .tx_drive_in,
  .scl_in, .scl_out, .scl_oe_out, .sda_in, .sda_out, .sda_oe_out,
  .port_function_out, .mode_out, .rx_enabled_out, .irq_out);

/* File: tb/i2cmc_bus_node.sv */
// Behavioural far bus node that pulls the open-drain lines to send one frame.
`timescale 1ns/1ps
module i2cmc_bus_node (
  // System clock for bit timing.
  input  wire clk_in,
  // Open-drain pulls, high means the line is held low.
  output reg  scl_low_out,
  output reg  sda_low_out
);
  localparam int HALF = 20; // Half bit time in system clocks.
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  // Waits one half bit time.
  task automatic tick;
    repeat (HALF) @(posedge clk_in);
  endtask
  // Sends start, one byte MSB first, a ninth clock with data released, then stop.
  task automatic send_frame(input logic [7:0] b);
    int i;
    sda_low_out <= 1'b1;
    tick();
    scl_low_out <= 1'b1;
    for (i = 7; i >= 0; i--) begin
      sda_low_out <= !b[i];
      tick();
      scl_low_out <= 1'b0;
      tick();
      scl_low_out <= 1'b1;
    end
    sda_low_out <= 1'b0;
    tick();
    scl_low_out <= 1'b0;
    tick();
    scl_low_out <= 1'b1;
    sda_low_out <= 1'b1;
    tick();
    scl_low_out <= 1'b0;
    tick();
    sda_low_out <= 1'b0;
    tick();
  endtask
endmodule // i2cmc_bus_node

/* File: tb/testbench.sv */
// Self-checking bench for the mode and clock control block.
`timescale 1ns/1ps
module testbench;
  reg clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  reg arb_lost_in = 1'b0, overrun_in = 1'b0, tx_bit_in = 1'b1, tx_drive_in = 1'b0;
  reg [2:0] addr_in = 3'h0;
  reg [7:0] wdata_in = 8'h00;
  wire [7:0] rdata_out;
  wire [1:0] mode_out;
  wire scl_out, scl_oe_out, sda_out, sda_oe_out, port_function_out, rx_enabled_out, irq_out;
  wire p_scl_low, p_sda_low;
  // Pull-ups win unless a party drives the line.
  wire scl = scl_oe_out ? scl_out : !p_scl_low;
  wire sda = sda_oe_out ? sda_out : !p_sda_low;
  int fails = 0, compares = 0, hi, lo, k, c;
  int per[16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};
  reg [7:0] d;
  always #50 clk_in = !clk_in;
  i2cmc_top i_i2cmc_top (.clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .arb_lost_in, .overrun_in, .tx_bit_in, .tx_drive_in, .scl_in(scl),
    .scl_out, .scl_oe_out, .sda_in(sda), .sda_out, .sda_oe_out, .port_function_out,
    .mode_out, .rx_enabled_out, .irq_out);
  i2cmc_bus_node i_i2cmc_bus_node (.clk_in, .scl_low_out(p_scl_low), .sda_low_out(p_sda_low));
  // ************************************************************
  // Bus tasks and comparison.
  // ************************************************************
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // Pulses one engine event, then lets the updating edge land.
  task automatic ev(input bit ovr);
    @(posedge clk_in);
    if (ovr) overrun_in <= 1'b1;
    else arb_lost_in <= 1'b1;
    @(posedge clk_in);
    overrun_in <= 1'b0;
    arb_lost_in <= 1'b0;
    #1;
  endtask
  // Counts negedges while the clock drive enable equals lvl, bounded.
  task automatic span(input bit lvl, output int n);
    n = 0;
    while (scl_oe_out === lvl && n < 600) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 600) begin
      fails++;
      tally_and_finish();
    end
  endtask
  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    tx_drive_in <= 1'b1;
    tx_bit_in <= 1'b0;
    #1;
    rd(3'h0, d);
    chk(d, 8'h00);
    rd(3'h7, d);
    chk(d, 8'h00);
    chk({port_function_out, scl_oe_out, sda_oe_out, mode_out, rx_enabled_out}, 6'h21);
    $display("Test reset and halt done");
    for (c = 0; c < 4; c++) begin
      wr(3'h0, 8'h80 | (c << 4));
      chk(mode_out, c[1:0]);
      chk({port_function_out, sda_oe_out}, 2'h1);
    end
    tx_drive_in <= 1'b0;
    $display("Test mode table done");
    for (c = 0; c < 16; c++) begin
      wr(3'h0, 8'h00);
      wr(3'h0, 8'hA0 | c);
      span(1'b0, k);
      span(1'b1, hi);
      span(1'b0, lo);
      chk(hi, per[c] / 2);
      chk(lo, per[c] - per[c] / 2);
    end
    wr(3'h0, 8'h8F);
    repeat (300) @(negedge clk_in);
    chk(scl_oe_out, 1'b0);
    $display("Test divider table done");
    wr(3'h4, 8'h0F);
    wr(3'h0, 8'hB5);
    wr(3'h5, 8'h00);
    ev(1'b0);
    chk(mode_out, 2'h0);
    rd(3'h3, d);
    chk({d, irq_out}, 9'h002);
    wr(3'h5, 8'h01);
    chk(irq_out, 1'b1);
    wr(3'h4, 8'h01);
    chk(irq_out, 1'b0);
    $display("Test arbitration loss done");
    wr(3'h2, 8'h01);
    wr(3'h0, 8'hB3);
    chk(scl_oe_out, 1'b1);
    ev(1'b1);
    chk(mode_out, 2'h1);
    rd(3'h3, d);
    chk(d, 8'h02);
    wr(3'h4, 8'h0F);
    wr(3'h2, 8'h00);
    $display("Test overrun done");
    wr(3'h1, 8'hB4);
    wr(3'h0, 8'h80);
    rd(3'h6, d);
    chk(rx_enabled_out, 1'b1);
    i_i2cmc_bus_node.send_frame(8'hB5);
    chk(mode_out, 2'h1);
    rd(3'h3, d);
    chk(d, 8'h0C);
    wr(3'h0, 8'hC0);
    rd(3'h6, d);
    chk({d, rx_enabled_out}, 9'h16A);
    wr(3'h0, 8'h80);
    rd(3'h6, d);
    chk(rx_enabled_out, 1'b1);
    $display("Test address match done");
    tally_and_finish();
  end
endmodule // testbench
